// >>> core/egd_pkg.sv
package egd_pkg;

    // ==========================================================
    // Table geometry
    // ==========================================================
    localparam int unsigned NUM_LEVELS = 8;
    localparam int unsigned DUR_WIDTH = 8;
    localparam logic [3:0] FIRST_LEVEL = 4'h4;
    localparam logic [3:0] LAST_LEVEL = 4'hB;

    // ==========================================================
    // Command word layout
    // ==========================================================
    localparam int unsigned CODE_MSB = 15;
    localparam int unsigned CODE_LSB = 8;
    localparam int unsigned DATA_MSB = 7;
    localparam int unsigned DATA_LSB = 0;

    // ==========================================================
    // Command codes, index 0 is level 4, index 7 is level 11
    // ==========================================================
    localparam logic [7:0] CODE_LEVEL4 = 8'h30;
    localparam logic [7:0] CODE_LEVEL5 = 8'h38;
    localparam logic [7:0] CODE_LEVEL6 = 8'h37;
    localparam logic [7:0] CODE_LEVEL7 = 8'h36;
    localparam logic [7:0] CODE_LEVEL8 = 8'h35;
    localparam logic [7:0] CODE_LEVEL9 = 8'h24;
    localparam logic [7:0] CODE_LEVEL10 = 8'h33;
    localparam logic [7:0] CODE_LEVEL11 = 8'h32;
    localparam logic [7:0] CMD_CODE [NUM_LEVELS] = '{CODE_LEVEL4, CODE_LEVEL5, CODE_LEVEL6,
        CODE_LEVEL7, CODE_LEVEL8, CODE_LEVEL9, CODE_LEVEL10, CODE_LEVEL11};

    // ==========================================================
    // Values after reset, same index order
    // ==========================================================
    localparam logic [7:0] RESET_DUR [NUM_LEVELS] = '{8'h03, 8'h05, 8'h08, 8'h0C,
        8'h12, 8'h1A, 8'h27, 8'h39};

    // ==========================================================
    // Display modes and sequencer states
    // ==========================================================
    typedef enum logic [1:0] {
        MODE_MONO = 2'b00,
        MODE_GRAY4 = 2'b01,
        MODE_GRAY16 = 2'b10,
        MODE_GRAY64 = 2'b11
    } egd_mode_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } egd_state_type;

endpackage

// >>> core/egd_step_timer.sv
module egd_step_timer #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic load_in,
    input wire logic [WIDTH-1:0] value_in,
    input wire logic tick_in,
    // Status
    output logic busy_out,
    output logic done_out
);

    // ==========================================================
    // Checks
    // ==========================================================
    if (WIDTH < 1) begin : g_bad_width
        $error("egd_step_timer: WIDTH must be at least 1");
    end

    // ==========================================================
    // Down counter, N loaded gives N+1 ticks
    // ==========================================================
    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic busy_q, busy_d;

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        if (load_in) begin
            cnt_d = value_in;
            busy_d = 1'b1;
        end else if (busy_q && tick_in) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign busy_out = busy_q;
    // Done is flagged ahead of the last counted tick edge so the next level loads on that
    // edge; independent of load_in to avoid a loop through the sequencer
    assign done_out = busy_q && tick_in && (cnt_q == '0);

endmodule // egd_step_timer

// >>> core/egd_even_duration_table.sv
// Overview of operation
// - Each entry N makes its gray level last N plus one gray-scale clock periods.
// - Code 32h loads the level 11 entry; it resets to 39h.
// - A level 10 entry exists and resets to 27h.
// - Code 24h loads the level 9 entry; it resets to 1Ah.
// - Code 35h loads the level 8 entry; it resets to 12h.
// - Code 36h loads the level 7 entry; it resets to 0Ch.
// - Code 37h loads the level 6 entry; it resets to 08h.
// - A level 5 entry exists and resets to 05h.
// - Code 30h loads the level 4 entry; it resets to 03h.
// - Write-only 16-bit word: code in bits 15..8, data in bits 7..0.
module egd_even_duration_table (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // Command port from the host interface
    input wire logic CMD_VALID_IN,
    input wire logic [15:0] CMD_WORD_IN,
    input wire logic [1:0] GRAY_MODE_IN,
    // Row timing
    input wire logic SCLK_EN_IN,
    input wire logic ROW_START_IN,
    // Status
    output logic LOAD_ACK_OUT,
    output logic LOAD_REFUSED_OUT,
    output logic STEP_ACTIVE_OUT,
    output logic [3:0] LEVEL_OUT,
    output logic STEP_DONE_OUT,
    output logic ROW_DONE_OUT
);

    localparam int unsigned N = egd_pkg::NUM_LEVELS;
    localparam int unsigned W = egd_pkg::DUR_WIDTH;

    // ==========================================================
    // Checks
    // ==========================================================
    // Codes and reset values are tabled for exactly eight 8-bit entries
    if (N != 8) begin : g_bad_levels
        $error("egd_even_duration_table: the table holds exactly 8 levels");
    end
    if (W != 8) begin : g_bad_width
        $error("egd_even_duration_table: entries are 8 bits wide");
    end

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rst_meta_q, rst_sync_q;

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // Command decode
    // ==========================================================
    logic [7:0] cmd_code;
    logic [7:0] cmd_data;
    logic mode_ok;
    logic [N-1:0] hit;

    assign cmd_code = CMD_WORD_IN[egd_pkg::CODE_MSB:egd_pkg::CODE_LSB];
    assign cmd_data = CMD_WORD_IN[egd_pkg::DATA_MSB:egd_pkg::DATA_LSB];
    // Loads in forbidden modes are dropped so a stray write cannot corrupt timing
    assign mode_ok = (egd_pkg::egd_mode_type'(GRAY_MODE_IN) == egd_pkg::MODE_GRAY16);

    // ==========================================================
    // Duration entries, write-only storage
    // ==========================================================
    logic [W-1:0] dur_q [N];
    logic [W-1:0] dur_d [N];

    for (genvar i = 0; i < N; i++) begin : g_entry
        // Each entry matches its own code: 30h,38h,37h,36h,35h,24h,33h,32h
        assign hit[i] = CMD_VALID_IN && (cmd_code == egd_pkg::CMD_CODE[i]);

        always_comb begin
            dur_d[i] = dur_q[i];
            if (hit[i] && mode_ok) begin
                dur_d[i] = cmd_data;
            end
        end

        always_ff @(posedge CLK_SYS_IN or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
                dur_q[i] <= egd_pkg::RESET_DUR[i];
            end else begin
                dur_q[i] <= dur_d[i];
            end
        end
    end

    // ==========================================================
    // Load status
    // ==========================================================
    logic ack_q, ack_d;
    logic refused_q, refused_d;

    always_comb begin
        ack_d = (|hit) && mode_ok;
        refused_d = (|hit) && !mode_ok;
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ack_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            refused_q <= refused_d;
        end
    end

    // ==========================================================
    // Row step sequencer, levels 4 up to 11
    // ==========================================================
    egd_pkg::egd_state_type state_q, state_d;
    logic [3:0] level_q, level_d;
    logic row_done_q, row_done_d;
    logic step_done_q, step_done_d;
    logic active_q, active_d;
    logic tmr_load;
    logic [W-1:0] tmr_value;
    logic tmr_done;
    logic [2:0] idx;

    assign idx = 3'(level_d - egd_pkg::FIRST_LEVEL);

    always_comb begin
        state_d = state_q;
        level_d = level_q;
        row_done_d = 1'b0;
        step_done_d = 1'b0;
        tmr_load = 1'b0;
        case (state_q)
            egd_pkg::ST_IDLE: begin
                if (ROW_START_IN) begin
                    state_d = egd_pkg::ST_RUN;
                    level_d = egd_pkg::FIRST_LEVEL;
                    tmr_load = 1'b1;
                end
            end
            egd_pkg::ST_RUN: begin
                if (ROW_START_IN) begin
                    // A new row restarts the sequence
                    level_d = egd_pkg::FIRST_LEVEL;
                    tmr_load = 1'b1;
                end else if (tmr_done) begin
                    step_done_d = 1'b1;
                    if (level_q == egd_pkg::LAST_LEVEL) begin
                        state_d = egd_pkg::ST_IDLE;
                        row_done_d = 1'b1;
                    end else begin
                        level_d = level_q + 4'h1;
                        tmr_load = 1'b1;
                    end
                end
            end
            default: begin
                state_d = egd_pkg::ST_IDLE;
            end
        endcase
        // Active flag kept in a flop of its own for the output
        active_d = (state_d == egd_pkg::ST_RUN);
    end

    // The entry as stored before the level starts sets its length
    assign tmr_value = dur_q[idx];

    always_ff @(posedge CLK_SYS_IN or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= egd_pkg::ST_IDLE;
            level_q <= egd_pkg::FIRST_LEVEL;
            row_done_q <= 1'b0;
            step_done_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            state_q <= state_d;
            level_q <= level_d;
            row_done_q <= row_done_d;
            step_done_q <= step_done_d;
            active_q <= active_d;
        end
    end

    // ==========================================================
    // Step timer
    // ==========================================================
    // Shared by all levels; reloaded on the edge that ends each level before level 11
    egd_step_timer #(
        .WIDTH(W)
    ) egd_step_timer_i (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_sync_q),
        .load_in(tmr_load),
        .value_in(tmr_value),
        .tick_in(SCLK_EN_IN),
        .busy_out(),
        .done_out(tmr_done)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    assign LOAD_ACK_OUT = ack_q;
    assign LOAD_REFUSED_OUT = refused_q;
    assign STEP_ACTIVE_OUT = active_q;
    assign LEVEL_OUT = level_q;
    assign STEP_DONE_OUT = step_done_q;
    assign ROW_DONE_OUT = row_done_q;

endmodule // egd_even_duration_table

// >>> tb/egd_host_model.sv
module egd_host_model (
    // Clock
    input wire logic clk_in,
    // Command port
    output logic cmd_valid_out,
    output logic [15:0] cmd_word_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_word_out = 16'h0000;
    end
    // ==========================================================
    // One command word, held through its sampling edge
    // ==========================================================
    task automatic send(input logic [7:0] code, input logic [7:0] data);
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_word_out <= {code, data};
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        cmd_word_out <= ~{code, data};
    endtask
endmodule // egd_host_model

// >>> tb/egd_even_duration_table_asserts.sv
module egd_even_duration_table_asserts (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // Inputs
    input wire logic CMD_VALID_IN,
    input wire logic [15:0] CMD_WORD_IN,
    input wire logic [1:0] GRAY_MODE_IN,
    input wire logic SCLK_EN_IN,
    input wire logic ROW_START_IN,
    // Outputs
    input wire logic LOAD_ACK_OUT,
    input wire logic LOAD_REFUSED_OUT,
    input wire logic STEP_ACTIVE_OUT,
    input wire logic [3:0] LEVEL_OUT,
    input wire logic STEP_DONE_OUT,
    input wire logic ROW_DONE_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    logic hit;
    assign hit = CMD_VALID_IN && (CMD_WORD_IN[15:8] inside {egd_pkg::CMD_CODE});
    // ==========================================================
    // Command port
    // ==========================================================
    AST_ACK: assert property (hit && GRAY_MODE_IN == 2'b10 |=> LOAD_ACK_OUT && !LOAD_REFUSED_OUT)
        else $error("load not acknowledged");
    AST_REFUSE: assert property (hit && GRAY_MODE_IN != 2'b10 |=> LOAD_REFUSED_OUT && !LOAD_ACK_OUT)
        else $error("load in forbidden mode not refused");
    AST_QUIET: assert property (!hit |=> !LOAD_ACK_OUT && !LOAD_REFUSED_OUT)
        else $error("load pulse without a table command");
    // ==========================================================
    // Row sequencer
    // ==========================================================
    AST_START: assert property (ROW_START_IN |=> STEP_ACTIVE_OUT && LEVEL_OUT == 4'h4)
        else $error("row start did not begin at level 4");
    AST_STEP: assert property (STEP_DONE_OUT && !ROW_DONE_OUT |-> LEVEL_OUT == $past(LEVEL_OUT) + 4'h1)
        else $error("level did not advance by one");
    AST_ROWEND: assert property (ROW_DONE_OUT |-> STEP_DONE_OUT && !STEP_ACTIVE_OUT && $past(LEVEL_OUT) == 4'hB)
        else $error("row end not after level 11");
    AST_TICK: assert property (STEP_DONE_OUT |-> $past(SCLK_EN_IN) && $past(STEP_ACTIVE_OUT))
        else $error("step ended without a gray clock tick");
    AST_IDLE: assert property (!STEP_ACTIVE_OUT && !ROW_START_IN |=> !STEP_DONE_OUT && !STEP_ACTIVE_OUT)
        else $error("sequencer moved while idle");
    AST_RANGE: assert property (LEVEL_OUT >= 4'h4 && LEVEL_OUT <= 4'hB)
        else $error("level outside 4 to 11");
endmodule // egd_even_duration_table_asserts

bind egd_even_duration_table egd_even_duration_table_asserts egd_even_duration_table_asserts_i (.CLK_SYS_IN,
    .RST_N_IN, .CMD_VALID_IN, .CMD_WORD_IN, .GRAY_MODE_IN, .SCLK_EN_IN, .ROW_START_IN, .LOAD_ACK_OUT,
    .LOAD_REFUSED_OUT, .STEP_ACTIVE_OUT, .LEVEL_OUT, .STEP_DONE_OUT, .ROW_DONE_OUT);

// >>> tb/egd_even_duration_table_bench.sv
module egd_even_duration_table_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CODES [8] = '{8'h30, 8'h38, 8'h37, 8'h36, 8'h35, 8'h24, 8'h33, 8'h32};
    localparam logic [7:0] VALS [8] = '{8'h00, 8'hFF, 8'h01, 8'h7F, 8'h02, 8'h80, 8'h00, 8'h03};
    logic [7:0] dur [8] = '{8'h03, 8'h05, 8'h08, 8'h0C, 8'h12, 8'h1A, 8'h27, 8'h39};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] mode = 2'b10;
    logic sclk_en = 1'b1;
    logic row_start = 1'b0;
    logic cmd_valid, ack, refused, active, step_done, row_done;
    logic [15:0] cmd_word;
    logic [3:0] level;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #25 clk = ~clk;
    egd_host_model egd_host_model_i (.clk_in(clk), .cmd_valid_out(cmd_valid), .cmd_word_out(cmd_word));
    egd_even_duration_table egd_even_duration_table_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
        .CMD_VALID_IN(cmd_valid), .CMD_WORD_IN(cmd_word), .GRAY_MODE_IN(mode), .SCLK_EN_IN(sclk_en),
        .ROW_START_IN(row_start), .LOAD_ACK_OUT(ack), .LOAD_REFUSED_OUT(refused), .STEP_ACTIVE_OUT(active),
        .LEVEL_OUT(level), .STEP_DONE_OUT(step_done), .ROW_DONE_OUT(row_done));
    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // Load one entry, expected {ack, refused}
    // ==========================================================
    task automatic load(input logic [7:0] code, input logic [7:0] data, input int idx, input logic [1:0] exp);
        egd_host_model_i.send(code, data);
        @(negedge clk);
        check({14'h0000, ack, refused}, {14'h0000, exp});
        if (exp == 2'b10) begin
            dur[idx] = data;
        end
    endtask
    // ==========================================================
    // One row: each level lasts its entry plus one ticks
    // ==========================================================
    task automatic run_row;
        int cnt;
        @(posedge clk);
        row_start <= 1'b1;
        @(posedge clk);
        row_start <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            cnt = (i == 0) ? -1 : 0;
            do begin
                @(negedge clk);
                cnt++;
            end while (step_done !== 1'b1 && cnt < 300);
            if (cnt >= 300) begin
                n_mismatch++;
                print_verdict();
            end
            check(16'(cnt), 16'(dur[i]) + 16'h0001);
            check({15'h0000, row_done}, {15'h0000, i == 7});
            check({15'h0000, active}, {15'h0000, i != 7});
            if (i < 7) begin
                check({12'h000, level}, 16'(5 + i));
            end
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({12'h000, level}, 16'h0004);
        check({13'h0000, active, ack, refused}, 16'h0000);
        run_row();
        for (int i = 0; i < 8; i++) begin
            load(CODES[i], VALS[i], i, 2'b10);
        end
        load(8'h31, 8'h55, 0, 2'b00);
        run_row();
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            mode <= (m == 2) ? 2'b11 : 2'(m);
            load(CODES[m], 8'h44, m, 2'b01);
        end
        @(posedge clk);
        mode <= 2'b10;
        @(posedge clk);
        row_start <= 1'b1;
        @(posedge clk);
        row_start <= 1'b0;
        repeat (10) @(posedge clk);
        run_row();
        print_verdict();
    end
endmodule // egd_even_duration_table_bench
